// [design/ebs_defs.svh]
// Purpose: offsets, fields, resets and timing of the bank select block
// Assumes: 32-bit APB, byte addresses
// Notes:   definitions only
`ifndef EBS_DEFS_SVH
`define EBS_DEFS_SVH
`define A_CTRL     8'h00
`define A_WAITS    8'h04
`define A_COMMON   8'h08
`define A_BPADDR   8'h0c
`define A_STATUS   8'h10
`define C_BANK     0
`define C_TFETCH   1
`define C_SER      2
`define C_HOLD     3
`define C_RSTEN    4
`define C_BPEN     5
`define CTRL_W     6
`define CTRL_RST   6'h14
`define S_BPHIT    0
`define S_RUN      1
`define S_BW       2
`define S_PEND     3
`define HALT_WS    4'h8
`define WS_RST     4'h0
`define COMMON_RST 16'h0000
`define BP_RST     17'h10000
`define CODE_BIT   16
`define FETCH_DLY_NS 10
`define CLK_NS     100
`define FETCH_DLY_CYC ((`FETCH_DLY_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [design/ebs_pkg.sv]
// Purpose: types of the bank select block
// Assumes: nothing
// Notes:   one-hot access states
package ebs_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_LO   = 4'h4,
      ST_HI   = 4'h8
   } acc_state_t;
endpackage

// [design/emulation_bank_select.sv]
// Purpose: pod glue for code/data banks, fetch gating and target paths
// Assumes: all inputs synchronous to pclk
// Notes:   configuration is written over APB
`timescale 1ns/100ps
`include "ebs_defs.svh"
module emulation_bank_select
   import ebs_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Bondout controller side
   input  wire logic        run_active,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_fetch,
   input  wire logic        cpu_req,
   input  wire logic        cpu_write,
   input  wire logic        cpu_word,
   input  wire logic [15:0] cpu_wdata,
   output logic             cpu_done,
   output logic             cpu_hold_req,
   output logic             cpu_rst_n,
   output logic             cpu_rxd,
   // Target side
   input  wire logic        tgt_hold_req,
   input  wire logic        tgt_rst_n,
   input  wire logic        bus_width_strap,
   input  wire logic        tgt_rxd,
   input  wire logic        conv_rxd,
   output logic             shared_port_pin,
   output logic             target_fetch,
   output logic             tgt_wr,
   output logic             tgt_byte,
   output logic [15:0]      tgt_waddr,
   output logic [15:0]      tgt_wdata,
   // Emulation RAM, map and trace
   output logic             gated_fetch,
   output logic             extended_addr_bit16,
   output logic [16:0]      map_addr,
   output logic             trace_valid,
   output logic [16:0]      trace_addr,
   output logic [15:0]      trace_data,
   output logic             bp_hit
);
   // ------------------------------------------------
   // Register file
   // ------------------------------------------------
   logic [`CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [`CTRL_W-1:0] act_r, act_nxt;
   logic [3:0]  ws_r, ws_nxt;
   logic [15:0] common_r, common_nxt;
   logic [16:0] bp_r, bp_nxt;
   logic        sticky_r, sticky_nxt;
   logic [31:0] rd_nxt;
   logic        rdy_nxt, err_nxt, wr_en;
   logic        bp_evt;
   logic        hit_map;

   always_comb begin
      hit_map = 1'b1;
      rd_nxt  = 32'h0;
      unique case (paddr)
         `A_CTRL:   rd_nxt[`CTRL_W-1:0] = ctrl_r;
         `A_WAITS:  rd_nxt[3:0] = ws_r;
         `A_COMMON: rd_nxt[15:0] = common_r;
         `A_BPADDR: rd_nxt[16:0] = bp_r;
         `A_STATUS: begin
            rd_nxt[`S_BPHIT] = sticky_r;
            rd_nxt[`S_RUN]   = run_active;
            rd_nxt[`S_BW]    = bus_width_strap;
            rd_nxt[`S_PEND]  = ctrl_r != act_r;
         end
         default: hit_map = 1'b0;
      endcase
      // Answer in the first access cycle, with no wait cycle, from the setup phase so every output is a flop
      rdy_nxt = psel & ~penable;
      err_nxt = psel & ~penable & ~hit_map;
      wr_en   = psel & penable & pready & pwrite & ~pslverr;
      ctrl_nxt   = ctrl_r;
      ws_nxt     = ws_r;
      common_nxt = common_r;
      bp_nxt     = bp_r;
      sticky_nxt = sticky_r;
      if (wr_en) begin
         unique case (paddr)
            `A_CTRL:   ctrl_nxt = pwdata[`CTRL_W-1:0];
            `A_WAITS:  ws_nxt = pwdata[3:0];
            `A_COMMON: common_nxt = pwdata[15:0];
            `A_BPADDR: bp_nxt = pwdata[16:0];
            `A_STATUS: if (pwdata[`S_BPHIT]) sticky_nxt = 1'b0;
            default: ;
         endcase
      end
      // A new hit wins over a clear in the same cycle
      if (bp_evt) sticky_nxt = 1'b1;
      // Selections reach the datapath only while halted
      act_nxt = run_active ? act_r : ctrl_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= `CTRL_RST;
         act_r    <= `CTRL_RST;
         ws_r     <= `WS_RST;
         common_r <= `COMMON_RST;
         bp_r     <= `BP_RST;
         sticky_r <= 1'b0;
         prdata   <= 32'h0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         ctrl_r   <= ctrl_nxt;
         act_r    <= act_nxt;
         ws_r     <= ws_nxt;
         common_r <= common_nxt;
         bp_r     <= bp_nxt;
         sticky_r <= sticky_nxt;
         prdata   <= rd_nxt;
         pready   <= rdy_nxt;
         pslverr  <= err_nxt;
      end
   end

   // ------------------------------------------------
   // Fetch gating and pass-through paths
   // ------------------------------------------------
   logic gf_nxt, a16_nxt, tf_nxt, hold_nxt;
   logic rst_nxt, rxd_nxt, pin_nxt;
   logic [16:0] map_nxt;

   always_comb begin
      // One flop stage stands for the short gate delay
      gf_nxt  = cpu_fetch | (cpu_addr < common_r);
      a16_nxt = act_r[`C_BANK] & gf_nxt;
      tf_nxt  = act_r[`C_TFETCH] ? gf_nxt : cpu_fetch;
      map_nxt = {gf_nxt, cpu_addr};
      hold_nxt = act_r[`C_HOLD] & run_active & tgt_hold_req;
      pin_nxt  = ~act_r[`C_HOLD] & tgt_hold_req;
      rst_nxt  = ~(act_r[`C_RSTEN] & ~tgt_rst_n);
      rxd_nxt  = act_r[`C_SER] ? conv_rxd : tgt_rxd;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gated_fetch         <= 1'b0;
         extended_addr_bit16 <= 1'b0;
         target_fetch        <= 1'b0;
         map_addr            <= 17'h0;
         cpu_hold_req        <= 1'b0;
         shared_port_pin     <= 1'b0;
         cpu_rst_n           <= 1'b1;
         cpu_rxd             <= 1'b1;
      end else begin
         gated_fetch         <= gf_nxt;
         extended_addr_bit16 <= a16_nxt;
         target_fetch        <= tf_nxt;
         map_addr            <= map_nxt;
         cpu_hold_req        <= hold_nxt;
         shared_port_pin     <= pin_nxt;
         cpu_rst_n           <= rst_nxt;
         cpu_rxd             <= rxd_nxt;
      end
   end

   // ------------------------------------------------
   // Access sequencer
   // ------------------------------------------------
   acc_state_t  st_r, st_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [15:0] ad_r, ad_nxt, dt_r, dt_nxt;
   logic        wr_r, wr_nxt, sp_r, sp_nxt, cf_r, cf_nxt;
   logic        take, first;
   logic [3:0]  wsel;
   logic        done_nxt, twr_nxt, tby_nxt, tv_nxt;
   logic [15:0] twa_nxt, twd_nxt;

   always_comb begin
      take  = (st_r == ST_IDLE) & cpu_req & ~cpu_done;
      wsel  = run_active ? ws_r : `HALT_WS;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      ad_nxt = ad_r;
      dt_nxt = dt_r;
      wr_nxt = wr_r;
      sp_nxt = sp_r;
      cf_nxt = cf_r;
      unique case (st_r)
         ST_IDLE: if (take) begin
            ad_nxt = cpu_addr;
            dt_nxt = cpu_wdata;
            wr_nxt = cpu_write;
            cf_nxt = cpu_fetch;
            sp_nxt = cpu_write & cpu_word & ~bus_width_strap;
            cnt_nxt = wsel;
            st_nxt = (wsel == 4'h0) ? ST_LO : ST_WAIT;
         end
         ST_WAIT: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) st_nxt = ST_LO;
         end
         ST_LO: st_nxt = sp_r ? ST_HI : ST_IDLE;
         ST_HI: st_nxt = ST_IDLE;
      endcase
      first = (st_nxt == ST_LO);
      done_nxt = (st_r != ST_IDLE) & (st_nxt == ST_IDLE);
      twr_nxt = wr_nxt & (first | (st_nxt == ST_HI));
      tby_nxt = sp_nxt & twr_nxt;
      twa_nxt = (st_nxt == ST_HI) ? ad_r + 16'h1 : ad_nxt;
      twd_nxt = dt_nxt;
      if (sp_nxt) twd_nxt = (st_nxt == ST_HI) ?
         {8'h00, dt_r[15:8]} : {8'h00, dt_nxt[7:0]};
      tv_nxt = first;
      // Data accesses never match, even at a code address
      bp_evt = take & cpu_fetch & act_r[`C_BPEN] &
               ({1'b1, cpu_addr} == bp_r);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r  <= ST_IDLE;
         cnt_r <= 4'h0;
         ad_r  <= 16'h0;
         dt_r  <= 16'h0;
         wr_r  <= 1'b0;
         sp_r  <= 1'b0;
         cf_r  <= 1'b0;
         cpu_done    <= 1'b0;
         tgt_wr      <= 1'b0;
         tgt_byte    <= 1'b0;
         tgt_waddr   <= 16'h0;
         tgt_wdata   <= 16'h0;
         trace_valid <= 1'b0;
         trace_addr  <= 17'h0;
         trace_data  <= 16'h0;
         bp_hit      <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         ad_r  <= ad_nxt;
         dt_r  <= dt_nxt;
         wr_r  <= wr_nxt;
         sp_r  <= sp_nxt;
         cf_r  <= cf_nxt;
         cpu_done    <= done_nxt;
         tgt_wr      <= twr_nxt;
         tgt_byte    <= tby_nxt;
         tgt_waddr   <= twa_nxt;
         tgt_wdata   <= twd_nxt;
         trace_valid <= tv_nxt;
         trace_addr  <= {cf_nxt, ad_nxt};
         trace_data  <= dt_nxt;
         bp_hit      <= bp_evt;
      end
   end

   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   halt_wait_a: assert property (take & ~run_active |=>
      (st_r == ST_WAIT)[*8] ##1 st_r == ST_LO)
      else $error("halted access not eight waits");
   hold_gate_a: assert property (act_r[`C_HOLD] & ~run_active
      |=> ~cpu_hold_req)
      else $error("hold passed while emulator controls");
   bank_hi_a: assert property (act_r[`C_BANK] & cpu_fetch
      & $stable(act_r) |=> extended_addr_bit16)
      else $error("code access not in high page");
   gate_cause_a: assert property (gated_fetch |->
      $past(cpu_fetch) | ($past(cpu_addr) < $past(common_r)))
      else $error("gated fetch high without cause");
   gate_dly_a: assert property ($rose(cpu_fetch)
      |=> gated_fetch)
      else $error("gated fetch not one stage later");
   bank_low_a: assert property (~act_r[`C_BANK]
      & $stable(act_r) |=> ~extended_addr_bit16)
      else $error("bank bit not tied low");
   raw_fetch_a: assert property (~act_r[`C_TFETCH]
      & $stable(act_r) |=> target_fetch == $past(cpu_fetch))
      else $error("target fetch not raw flag");
   code_or_a: assert property (map_addr
      == {gated_fetch, $past(cpu_addr)})
      else $error("map address page bit wrong");
   bp_code_a: assert property (bp_hit |-> $past(cpu_fetch))
      else $error("breakpoint on data access");
   split_two_a: assert property (take & cpu_write & cpu_word
      & ~bus_width_strap & run_active & ws_r == 4'h0
      |=> tgt_wr & tgt_byte & trace_valid
      ##1 tgt_wr & tgt_byte & ~trace_valid)
      else $error("byte split or single frame broken");
   rst_off_a: assert property (~act_r[`C_RSTEN]
      & $stable(act_r) |=> cpu_rst_n)
      else $error("target reset forwarded while off");
   rxd_src_a: assert property (act_r[`C_SER]
      & $stable(act_r) |=> cpu_rxd == $past(conv_rxd))
      else $error("serial input from wrong source");
   cfg_hold_a: assert property (run_active
      |=> act_r == $past(act_r))
      else $error("selection changed while running");
endmodule

// [test/target_board.sv]
// Purpose: target board seen from the pod glue
// Assumes: bench sets the board's levels and links
// Notes:   keeps a small byte memory of write beats
`timescale 1ns/100ps
module target_board (
   // Clock
   input  wire logic        pclk,
   // Board settings from the bench
   input  wire logic        hold_want,
   input  wire logic        rst_want,
   input  wire logic        wide_bus,
   input  wire logic        rx_linked,
   input  wire logic        rx_bit,
   // Pod side
   input  wire logic        tgt_wr,
   input  wire logic        tgt_byte,
   input  wire logic [15:0] tgt_waddr,
   input  wire logic [15:0] tgt_wdata,
   output logic             tgt_hold_req,
   output logic             tgt_rst_n,
   output logic             bus_width_strap,
   output logic             tgt_rxd
);
   logic [7:0] mem [0:255];
   int         beats = 0;
   logic       idle_rxd = 1'b0;

   assign tgt_hold_req    = hold_want;
   // Watchdog on the board pulls the line low
   assign tgt_rst_n       = ~rst_want;
   assign bus_width_strap = wide_bus;
   // Unlinked line has no stable level, so it toggles
   assign tgt_rxd         = rx_linked ? rx_bit : idle_rxd;

   always @(posedge pclk) begin
      idle_rxd <= ~idle_rxd;
      if (tgt_wr === 1'b1) begin
         beats <= beats + 1;
         if (tgt_byte) begin
            mem[tgt_waddr[7:0]] <= tgt_wdata[7:0];
         end else begin
            {mem[tgt_waddr[7:0] + 8'h01], mem[tgt_waddr[7:0]]} <= tgt_wdata;
         end
      end
   end
endmodule

// [test/emulation_bank_select_tb.sv]
// Purpose: self-checking bench for the bank select glue
// Assumes: one 10 MHz clock, APB master tasks
// Notes:   far side is the target_board model
`timescale 1ns/100ps
`include "ebs_defs.svh"
module emulation_bank_select_tb
   import ebs_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        err, run_active, cpu_fetch, cpu_req, cpu_write, cpu_word;
   logic [15:0] cpu_addr, cpu_wdata, tgt_waddr, tgt_wdata, last_trace;
   logic        cpu_done, cpu_hold_req, cpu_rst_n, cpu_rxd, conv_rxd;
   logic        tgt_hold_req, tgt_rst_n, bus_width_strap, tgt_rxd;
   logic        shared_port_pin, target_fetch, tgt_wr, tgt_byte;
   logic        gated_fetch, extended_addr_bit16, trace_valid, bp_hit;
   logic [16:0] map_addr, trace_addr, last_taddr;
   logic [15:0] trace_data;
   logic        hold_want, rst_want, wide_bus, rx_linked, rx_bit;
   int          n_mismatch = 0, tests_run = 0, n_trace = 0, n_bp = 0;
   localparam logic [15:0] ADR [3] = '{16'h9000, 16'h9000, 16'h2000};
   localparam logic [2:0]  FCH = 3'b010;
   localparam logic [2:0]  GF  = 3'b110;

   emulation_bank_select u_dut (.*);
   target_board          u_tgt (.*);

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(negedge pclk) begin
      if (trace_valid === 1'b1) begin
         n_trace++;
         last_trace = trace_data;
         last_taddr = trace_addr;
      end
      if (bp_hit === 1'b1) n_bp++;
   end

   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer is taken at the rising edge that samples pready high
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, rd, err);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0, rd, err);
      chk(rd, exp);
   endtask

   // Count edges from request to done, done edge included
   task automatic acc(input logic [15:0] a, input logic f, input logic w,
                      input logic wd, input logic [15:0] d, input int x);
      int n;
      @(posedge pclk);
      cpu_addr <= a;
      cpu_fetch <= f;
      cpu_write <= w;
      cpu_word <= wd;
      cpu_wdata <= d;
      cpu_req <= 1'b1;
      n = 0;
      // Done is taken at the edge that samples it high; drop the request there
      do begin
         @(posedge pclk);
         n++;
      end while (cpu_done !== 1'b1);
      cpu_req <= 1'b0;
      #1;
      chk(n, x);
   endtask

   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ------------------------------------------------
   // Sequence
   // ------------------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, run_active, cpu_fetch, cpu_req} = '0;
      {cpu_write, cpu_word, hold_want, rst_want, rx_linked, rx_bit} = '0;
      {paddr, pwdata, cpu_addr, cpu_wdata, conv_rxd} = '0;
      wide_bus = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`A_CTRL, 32'h14);
      rdc(`A_WAITS, 32'h0);
      rdc(`A_BPADDR, 32'h10000);
      apb(8'h14, 1'b0, 32'h0, rd, err);
      chk({rd[30:0], err}, 32'h1);
      settle();
      chk(cpu_rxd, 1'b0);
      wr(`A_CTRL, 32'h10);
      @(posedge pclk);
      rx_linked <= 1'b1;
      conv_rxd <= 1'b1;
      rst_want <= 1'b1;
      hold_want <= 1'b1;
      settle();
      chk(cpu_rxd, 1'b0);
      chk(cpu_rst_n, 1'b0);
      chk(shared_port_pin, 1'b1);
      // Hold mode on, reset path off
      wr(`A_CTRL, 32'h08);
      settle();
      chk(cpu_rst_n, 1'b1);
      chk(cpu_hold_req, 1'b0);
      @(posedge pclk);
      run_active <= 1'b1;
      settle();
      chk(cpu_hold_req, 1'b1);
      wr(`A_CTRL, 32'h27);
      rdc(`A_STATUS, 32'he);
      @(posedge pclk);
      run_active <= 1'b0;
      rst_want <= 1'b0;
      hold_want <= 1'b0;
      settle();
      rdc(`A_STATUS, 32'h4);
      chk(cpu_rxd, 1'b1);
      wr(`A_COMMON, 32'h8000);
      wr(`A_BPADDR, 32'h12090);
      wr(`A_WAITS, 32'h3);
      acc(16'h9000, 1'b0, 1'b0, 1'b0, 16'h0, 11);
      @(posedge pclk);
      run_active <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         acc(ADR[i], FCH[i], 1'b0, 1'b0, 16'h0, 6);
         chk(gated_fetch, GF[i]);
         chk(extended_addr_bit16, GF[i]);
         chk(map_addr, {GF[i], ADR[i]});
         chk(target_fetch, GF[i]);
      end
      @(posedge pclk);
      cpu_addr <= 16'h9000;
      #1;
      chk(gated_fetch, 1'b1);
      @(posedge pclk);
      #1;
      chk(gated_fetch, 1'b0);
      acc(16'h2090, 1'b1, 1'b0, 1'b0, 16'h0, 6);
      acc(16'h2090, 1'b0, 1'b0, 1'b0, 16'h0, 6);
      chk(n_bp, 1);
      rdc(`A_STATUS, 32'h7);
      wr(`A_STATUS, 32'h1);
      rdc(`A_STATUS, 32'h6);
      // No running waits, so the split walk is the shortest one
      wr(`A_WAITS, 32'h0);
      @(posedge pclk);
      wide_bus <= 1'b0;
      acc(16'h0040, 1'b0, 1'b1, 1'b1, 16'hbeef, 4);
      chk(u_tgt.beats, 2);
      chk({u_tgt.mem[8'h41], u_tgt.mem[8'h40]}, 16'hbeef);
      chk(last_trace, 16'hbeef);
      chk(last_taddr, 17'h00040);
      chk(n_trace, 7);
      finish_test();
   end

   // A hung handshake ends the run here
   initial begin
      #500000;
      n_mismatch++;
      finish_test();
   end
endmodule
